// File: rtl/ebfc_pkg.sv
package ebfc_pkg;

  // Clock rate and timing figures, each time in its printed unit
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned PULSE_FREQ_MHZ  = 500;         // 0.5 Hz timed brake cycle
  localparam int unsigned PULSE_HALF_CYC  = CLK_HZ / (PULSE_FREQ_MHZ * 2) * 1000;
  localparam int unsigned ACK_DELAY_S     = 2;           // Auto acknowledge delay
  localparam int unsigned ACK_DELAY_CYC   = CLK_HZ * ACK_DELAY_S;
  localparam int unsigned LED_PERIOD_MS   = 1000;        // One flash window
  localparam int unsigned LED_PERIOD_CYC  = CLK_HZ / 1000 * LED_PERIOD_MS;
  localparam int unsigned CNT_W           = 26;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_SPEED_LIMIT = 8'h04;
  localparam logic [7:0] OFS_STOP_DIST   = 8'h08;
  localparam logic [7:0] OFS_STATUS      = 8'h0C;
  localparam logic [7:0] OFS_MON_SPEED   = 8'h10;
  localparam logic [7:0] OFS_MON_DIST    = 8'h14;
  localparam logic [7:0] OFS_PSET_BASE   = 8'h20;        // 8 words, set 1 then set 2

  // Control register fields
  localparam int CTRL_PB_EN      = 0;
  localparam int CTRL_BRK_MON_EN = 1;
  localparam int CTRL_EARLY_EN   = 2;
  localparam int CTRL_DCP_MODE   = 3;
  localparam int CTRL_COPY       = 4;
  localparam int CTRL_FUNC_LSB   = 8;

  // Status register fields
  localparam int STAT_FAULT   = 0;
  localparam int STAT_LOCK    = 1;
  localparam int STAT_MON     = 2;
  localparam int STAT_SET2    = 3;
  localparam int STAT_SPEEDM  = 4;
  localparam int STAT_TIMEDM  = 5;
  localparam int STAT_COPY    = 6;
  localparam int STAT_EARLY   = 7;
  localparam int STAT_ERR_LSB = 16;

  // Reset values and codes
  localparam logic [7:0]  MONITOR_FUNC_CODE = 8'h29;     // Function code 41
  localparam logic [15:0] SPEED_LIMIT_RST   = 16'h003C;  // 60 mm/s
  localparam logic [15:0] STOP_DIST_RST     = 16'h0000;
  localparam logic [9:0]  ERR_POWER_LO      = 10'h384;   // 900
  localparam logic [9:0]  ERR_POWER_HI      = 10'h3E7;   // 999
  localparam logic [1:0]  PSET_V2_IDX       = 2'h1;
  localparam logic [1:0]  PSET_V3_IDX       = 2'h2;
  localparam logic [1:0]  PSET_LAST_IDX     = 2'h3;

  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_READ} ebfc_bus_e;
  typedef enum logic [1:0] {C_IDLE, C_READ, C_WRITE} ebfc_copy_e;

  // One control sample from the speed measurement
  typedef struct packed {
    logic        valid;      // Sample strobe
    logic [15:0] speed;      // Cabin speed, mm/s
    logic        dir_up;     // Direction of travel
    logic [7:0]  pos_delta;  // Signed travel since last sample, mm
  } ebfc_sample_s;

  // Whole state of the top module
  typedef struct packed {
    ebfc_bus_e   bphase;
    logic [7:0]  baddr;
    logic        bwrite;
    logic        bmapped;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        pb_en;
    logic        brk_mon_en;
    logic        early_en;
    logic        dcp_mode;
    logic [7:0]  mon_func;
    logic [15:0] speed_limit;
    logic [15:0] stop_dist;
    ebfc_copy_e  copy_st;
    logic [1:0]  copy_idx;
    logic        pb_contact;
    logic [CNT_W-1:0] pb_cnt;
    logic        fault;
    logic [9:0]  err_code;
    logic        lock;
    logic [CNT_W-1:0] ack_cnt;
    logic        fault_out;
    logic        ready_out;
    logic        brake_out;
    logic        early_close;
    logic        led;
    logic [CNT_W-1:0] led_cnt;
    logic        set2;
    logic        mon;
    logic        mon_dbl;
    logic        mon_up;
    logic [15:0] mon_speed;
    logic [23:0] mon_dist;
  } ebfc_state_s;

endpackage

// File: rtl/ebfc_pset_mem.sv
`timescale 1ns/1ns
// Parameter set store, set 1 in words 0..3 and set 2 in words 4..7
module ebfc_pset_mem (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        we,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata_r
);

  logic [15:0] mem_r [0:7];  // Storage words

  // Write port and registered read; contents cleared at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 16'h0000;
      for (int i = 0; i < 8; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else if (ce) begin
      if (we) begin
        mem_r[addr] <= wdata;
      end
      rdata_r <= mem_r[addr];
    end
  end

endmodule

// File: rtl/ebfc_top.sv
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module ebfc_top #(
  parameter int unsigned PULSE_HALF = ebfc_pkg::PULSE_HALF_CYC,
  parameter int unsigned ACK_DELAY  = ebfc_pkg::ACK_DELAY_CYC,
  parameter int unsigned LED_PERIOD = ebfc_pkg::LED_PERIOD_CYC
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic      [31:0]           hrdata,
  output logic                       hresp,
  input  wire ebfc_pkg::ebfc_sample_s sample,
  input  wire logic [3:0]            travel_req,
  input  wire logic                  rescue_active,
  input  wire logic                  install_stopped,
  input  wire logic                  encoder_ok,
  input  wire logic                  brake_open_fb,
  input  wire logic                  error_detect,
  input  wire logic [9:0]            error_code,
  input  wire logic                  monitor_din,
  input  wire logic                  power_fail_set_select,
  input  wire logic                  v1_switch_off,
  input  wire logic                  dist_valid,
  input  wire logic [15:0]           dist_remaining,
  output logic                       pulsed_brake_function,
  output logic                       fault_output,
  output logic                       drive_ready_output,
  output logic                       brake_control_output,
  output logic                       early_brake_close,
  output logic                       led_green,
  output logic                       set2_active,
  output logic                       monitor_active,
  output logic                       monitor_double_arrow,
  output logic                       monitor_dir_up,
  output logic      [15:0]           monitor_speed,
  output logic      [23:0]           monitor_distance
);

  ebfc_pkg::ebfc_state_s st_r;    // All state
  ebfc_pkg::ebfc_state_s st_nxt;  // Next state
  logic                  mem_we;  // Parameter store write
  logic [2:0]            mem_addr;
  logic [15:0]           mem_wdata;
  logic [15:0]           mem_rdata;

  // Parameter store; one port shared by copy sequencer and bus
  ebfc_pset_mem u_pset (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata_r (mem_rdata)
  );

  logic        accept;     // Address phase taken
  logic        speed_mode; // Speed-dependent cycle selected
  logic        timed_mode; // Timed cycle selected
  logic        travelling; // Any speed step requested
  logic        lock_code;  // Incoming error needs power cycle
  logic [31:0] status_w;   // Status word
  localparam int CNT_W_L = ebfc_pkg::CNT_W;  // Counter width

  logic [31:0] rd_w;       // Read mux
  logic [CNT_W_L-1:0] q_led;

  // Combined next-state logic
  always_comb begin
    st_nxt    = st_r;
    mem_we    = 1'b0;
    mem_addr  = 3'h0;
    mem_wdata = 16'h0000;
    q_led     = CNT_W_L'(LED_PERIOD / 4);
    accept    = hsel && htrans[1] && hready;
    travelling = |travel_req;
    lock_code = (error_code >= ebfc_pkg::ERR_POWER_LO) &&
                (error_code <= ebfc_pkg::ERR_POWER_HI);
    speed_mode = st_r.pb_en && rescue_active && encoder_ok;
    timed_mode = st_r.pb_en && !speed_mode && (install_stopped || !encoder_ok) &&
                 (!st_r.brk_mon_en || brake_open_fb);

    status_w = 32'h0000_0000;
    status_w[ebfc_pkg::STAT_FAULT]  = st_r.fault;
    status_w[ebfc_pkg::STAT_LOCK]   = st_r.lock;
    status_w[ebfc_pkg::STAT_MON]    = st_r.mon;
    status_w[ebfc_pkg::STAT_SET2]   = st_r.set2;
    status_w[ebfc_pkg::STAT_SPEEDM] = speed_mode;
    status_w[ebfc_pkg::STAT_TIMEDM] = timed_mode;
    status_w[ebfc_pkg::STAT_COPY]   = st_r.copy_st != ebfc_pkg::C_IDLE;
    status_w[ebfc_pkg::STAT_EARLY]  = st_r.early_close;
    status_w[ebfc_pkg::STAT_ERR_LSB +: 10] = st_r.err_code;

    // Read mux on the captured address
    rd_w = 32'h0000_0000;
    if (st_r.bmapped) begin
      if (st_r.baddr[5]) begin
        rd_w = {16'h0000, mem_rdata};
      end else begin
        case (st_r.baddr)
          ebfc_pkg::OFS_CTRL: begin
            rd_w[ebfc_pkg::CTRL_PB_EN]      = st_r.pb_en;
            rd_w[ebfc_pkg::CTRL_BRK_MON_EN] = st_r.brk_mon_en;
            rd_w[ebfc_pkg::CTRL_EARLY_EN]   = st_r.early_en;
            rd_w[ebfc_pkg::CTRL_DCP_MODE]   = st_r.dcp_mode;
            rd_w[ebfc_pkg::CTRL_COPY]       = st_r.copy_st != ebfc_pkg::C_IDLE;
            rd_w[ebfc_pkg::CTRL_FUNC_LSB +: 8] = st_r.mon_func;
          end
          ebfc_pkg::OFS_SPEED_LIMIT: rd_w = {16'h0000, st_r.speed_limit};
          ebfc_pkg::OFS_STOP_DIST:   rd_w = {16'h0000, st_r.stop_dist};
          ebfc_pkg::OFS_STATUS:      rd_w = status_w;
          ebfc_pkg::OFS_MON_SPEED:   rd_w = {16'h0000, st_r.mon_speed};
          ebfc_pkg::OFS_MON_DIST:    rd_w = {8'h00, st_r.mon_dist};
          default:                   rd_w = 32'h0000_0000;
        endcase
      end
    end

    // Copy sequencer owns the store while running
    // copy with V2 V3 limit
    case (st_r.copy_st)
      ebfc_pkg::C_IDLE: begin
      end
      ebfc_pkg::C_READ: begin
        mem_addr       = {1'b0, st_r.copy_idx};
        st_nxt.copy_st = ebfc_pkg::C_WRITE;
      end
      ebfc_pkg::C_WRITE: begin
        mem_we   = 1'b1;
        mem_addr = {1'b1, st_r.copy_idx};
        // Reduced supply allows only half the V2 and V3 speeds
        if (st_r.copy_idx == ebfc_pkg::PSET_V2_IDX ||
            st_r.copy_idx == ebfc_pkg::PSET_V3_IDX) begin
          mem_wdata = {1'b0, mem_rdata[15:1]};
        end else begin
          mem_wdata = mem_rdata;
        end
        if (st_r.copy_idx == ebfc_pkg::PSET_LAST_IDX) begin
          st_nxt.copy_st = ebfc_pkg::C_IDLE;
        end else begin
          st_nxt.copy_st = ebfc_pkg::C_READ;
        end
        st_nxt.copy_idx = st_r.copy_idx + 2'h1;
      end
      default: st_nxt.copy_st = ebfc_pkg::C_IDLE;
    endcase

    // Bus slave: two wait states, waits further while a copy runs
    case (st_r.bphase)
      ebfc_pkg::B_IDLE: begin
        if (accept) begin
          st_nxt.bphase    = ebfc_pkg::B_WAIT;
          st_nxt.baddr     = haddr[7:0];
          st_nxt.bmapped   = haddr[31:6] == 26'h0;
          st_nxt.bwrite    = hwrite;
          st_nxt.hreadyout = 1'b0;
        end
      end
      ebfc_pkg::B_WAIT: begin
        if (st_r.copy_st == ebfc_pkg::C_IDLE) begin
          st_nxt.bphase = ebfc_pkg::B_READ;
          if (st_r.bmapped && st_r.baddr[5]) begin
            mem_addr  = st_r.baddr[4:2];
            mem_we    = st_r.bwrite;
            mem_wdata = hwdata[15:0];
          end
          if (st_r.bwrite && st_r.bmapped && !st_r.baddr[5]) begin
            case (st_r.baddr)
              ebfc_pkg::OFS_CTRL: begin
                st_nxt.pb_en      = hwdata[ebfc_pkg::CTRL_PB_EN];
                st_nxt.brk_mon_en = hwdata[ebfc_pkg::CTRL_BRK_MON_EN];
                st_nxt.early_en   = hwdata[ebfc_pkg::CTRL_EARLY_EN];
                st_nxt.dcp_mode   = hwdata[ebfc_pkg::CTRL_DCP_MODE];
                st_nxt.mon_func   = hwdata[ebfc_pkg::CTRL_FUNC_LSB +: 8];
                // Copy selector falls back to off when the copy ends
                if (hwdata[ebfc_pkg::CTRL_COPY]) begin
                  st_nxt.copy_st  = ebfc_pkg::C_READ;
                  st_nxt.copy_idx = 2'h0;
                end
              end
              ebfc_pkg::OFS_SPEED_LIMIT: st_nxt.speed_limit = hwdata[15:0];
              ebfc_pkg::OFS_STOP_DIST:   st_nxt.stop_dist   = hwdata[15:0];
              default: begin
              end
            endcase
          end
        end
      end
      ebfc_pkg::B_READ: begin
        st_nxt.hrdata    = st_r.bwrite ? 32'h0000_0000 : rd_w;
        st_nxt.hreadyout = 1'b1;
        st_nxt.bphase    = ebfc_pkg::B_IDLE;
      end
      default: begin
        st_nxt.bphase    = ebfc_pkg::B_IDLE;
        st_nxt.hreadyout = 1'b1;
      end
    endcase
    st_nxt.hresp = 1'b0;

    st_nxt.set2 = power_fail_set_select;

    // monitor mode from function 41 input
    st_nxt.mon = monitor_din && (st_r.mon_func == ebfc_pkg::MONITOR_FUNC_CODE);

    if (st_nxt.mon && !st_r.mon) begin
      st_nxt.mon_dist = 24'h00_0000;
    end else if (st_r.mon && sample.valid) begin
      st_nxt.mon_speed = sample.speed;
      st_nxt.mon_up    = sample.dir_up;
      st_nxt.mon_dbl   = sample.speed > st_r.speed_limit;
      st_nxt.mon_dist  = st_r.mon_dist + {{16{sample.pos_delta[7]}}, sample.pos_delta};
    end

    // Pulsed brake output
    if (st_nxt.mon) begin
      st_nxt.pb_contact = 1'b0;
      st_nxt.pb_cnt     = '0;
    end else if (speed_mode) begin
      st_nxt.pb_cnt = '0;
      if (sample.valid) begin
        if (sample.speed > st_r.speed_limit) begin
          st_nxt.pb_contact = 1'b0;
        end else if (sample.speed < st_r.speed_limit) begin
          st_nxt.pb_contact = 1'b1;
        end
      end
    end else if (timed_mode) begin
      if (st_r.pb_cnt == CNT_W_L'(PULSE_HALF - 1)) begin
        st_nxt.pb_cnt     = '0;
        st_nxt.pb_contact = !st_r.pb_contact;
      end else begin
        st_nxt.pb_cnt = st_r.pb_cnt + CNT_W_L'(1);
      end
    end else begin
      // No evacuation cycle: contact open keeps the brake applied
      st_nxt.pb_contact = 1'b0;
      st_nxt.pb_cnt     = '0;
    end

    // Error latch and automatic acknowledge; a new error wins over the clear
    if (error_detect) begin
      st_nxt.fault    = 1'b1;
      st_nxt.err_code = error_code;
      st_nxt.ack_cnt  = '0;
      if (lock_code) begin
        st_nxt.lock = 1'b1;
      end
    end else if (st_r.fault && !st_r.lock) begin
      // 2 s with no travel signal
      if (travelling) begin
        st_nxt.ack_cnt = '0;
      end else if (st_r.ack_cnt == CNT_W_L'(ACK_DELAY - 1)) begin
        st_nxt.fault   = 1'b0;
        st_nxt.ack_cnt = '0;
      end else begin
        st_nxt.ack_cnt = st_r.ack_cnt + CNT_W_L'(1);
      end
    end

    // Early brake close, held until the travel request, set 2 or the early enable drops
    if (!travelling || !st_r.set2 || !st_r.early_en) begin
      st_nxt.early_close = 1'b0;
    end else if (!st_r.dcp_mode && v1_switch_off) begin
      st_nxt.early_close = 1'b1;
    end else if (st_r.dcp_mode && dist_valid && dist_remaining == st_r.stop_dist) begin
      st_nxt.early_close = 1'b1;
    end

    st_nxt.fault_out = !st_nxt.fault;
    st_nxt.ready_out = !st_nxt.fault && !st_nxt.mon;
    st_nxt.brake_out = !st_nxt.fault && !st_nxt.mon && travelling && !st_nxt.early_close;

    if (st_r.led_cnt == CNT_W_L'(LED_PERIOD - 1)) begin
      st_nxt.led_cnt = '0;
    end else begin
      st_nxt.led_cnt = st_r.led_cnt + CNT_W_L'(1);
    end
    if (st_nxt.fault || st_nxt.mon) begin
      st_nxt.led = 1'b0;
    end else if (travelling) begin
      st_nxt.led = (st_r.led_cnt < q_led) ||
                   ((st_r.led_cnt >= (q_led << 1)) && (st_r.led_cnt < (q_led * 3)));
    end else begin
      st_nxt.led = st_r.led_cnt < (q_led << 1);
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r             <= '0;
      st_r.bphase      <= ebfc_pkg::B_IDLE;
      st_r.copy_st     <= ebfc_pkg::C_IDLE;
      st_r.hreadyout   <= 1'b1;
      st_r.speed_limit <= ebfc_pkg::SPEED_LIMIT_RST;
      st_r.stop_dist   <= ebfc_pkg::STOP_DIST_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign hreadyout             = st_r.hreadyout;
  assign hrdata                = st_r.hrdata;
  assign hresp                 = st_r.hresp;
  assign pulsed_brake_function = st_r.pb_contact;
  assign fault_output          = st_r.fault_out;
  assign drive_ready_output    = st_r.ready_out;
  assign brake_control_output  = st_r.brake_out;
  assign early_brake_close     = st_r.early_close;
  assign led_green             = st_r.led;
  assign set2_active           = st_r.set2;
  assign monitor_active        = st_r.mon;
  assign monitor_double_arrow  = st_r.mon_dbl;
  assign monitor_dir_up        = st_r.mon_up;
  assign monitor_speed         = st_r.mon_speed;
  assign monitor_distance      = st_r.mon_dist;

endmodule

// File: dv/ebfc_top_asserts.sv
`timescale 1ns/1ns
// Port-level checks for the brake and fault block
module ebfc_top_asserts #(
  parameter int unsigned ACK_DELAY = 50
) (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   ce,
  input wire ebfc_pkg::ebfc_sample_s sample,
  input wire logic [3:0]             travel_req,
  input wire logic                   rescue_active,
  input wire logic                   encoder_ok,
  input wire logic                   error_detect,
  input wire logic [9:0]             error_code,
  input wire logic                   pulsed_brake_function,
  input wire logic                   fault_output,
  input wire logic                   drive_ready_output,
  input wire logic                   brake_control_output,
  input wire logic                   led_green,
  input wire logic                   monitor_active
);
  int unsigned quiet_cnt; // Cycles with no cause and no travel
  logic        was_down;  // A fault was shown since reset
  logic        locked;    // A power-cycle error was taken

  // Helper state; the count saturates so it never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_cnt <= 0;
      was_down  <= 1'h0;
      locked    <= 1'h0;
    end else if (ce) begin
      quiet_cnt <= (error_detect || travel_req != 4'h0) ? 0 : quiet_cnt + (quiet_cnt < 999);
      was_down  <= was_down || $fell(fault_output);
      locked    <= locked || (error_detect && error_code >= ebfc_pkg::ERR_POWER_LO
                   && error_code <= ebfc_pkg::ERR_POWER_HI);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_fault_drops_out: assert property (
    ce && error_detect |=> !fault_output && !drive_ready_output && !brake_control_output)
    else $error("drive outputs stay up in a fault");
  a_ready_needs_health: assert property (
    drive_ready_output |-> fault_output)
    else $error("ready shown during a fault");
  a_ack_after_quiet: assert property (
    $rose(fault_output) && was_down |-> quiet_cnt + 2 >= ACK_DELAY)
    else $error("fault cleared too soon");
  a_travel_blocks_ack: assert property (
    !fault_output && travel_req != 4'h0 |=> !fault_output)
    else $error("fault cleared during travel");
  a_locked_stays: assert property (
    locked |-> !fault_output)
    else $error("power-cycle error cleared");
  a_monitor_lockout: assert property (
    monitor_active && $past(monitor_active) |->
      !drive_ready_output && !brake_control_output && !pulsed_brake_function)
    else $error("drive active in monitor mode");
  a_speed_on_sample: assert property (
    $rose(pulsed_brake_function) && $past(rescue_active) && $past(encoder_ok) |->
      $past(sample.valid))
    else $error("contact closed without a sample");
  a_led_dark_fault: assert property (
    !fault_output && !$past(fault_output) |-> !led_green)
    else $error("travel led lit in fault");

  c_auto_ack: cover property ($rose(fault_output) && was_down);
  c_lock: cover property (locked);
  c_contact_drop: cover property ($fell(pulsed_brake_function));
endmodule

bind ebfc_top ebfc_top_asserts #(.ACK_DELAY(ACK_DELAY)) chk_u (
  .hclk, .hresetn, .ce, .sample, .travel_req, .rescue_active, .encoder_ok,
  .error_detect, .error_code, .pulsed_brake_function, .fault_output,
  .drive_ready_output, .brake_control_output, .led_green, .monitor_active
);

// File: dv/ebfc_lift_model.sv
`timescale 1ns/1ns
// Lift controller stand-in: passes travel commands while the drive is healthy
module ebfc_lift_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] travel_cmd,
  input  wire logic       retry,
  input  wire logic       fault_output,
  output logic      [3:0] travel_req_r
);
  // drop travel on fault
  // Retry is a deliberate misuse: travel requested during a fault
  // no standstill hold: travel ends with the command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      travel_req_r <= 4'h0;
    end else begin
      travel_req_r <= (fault_output || retry) ? travel_cmd : 4'h0;
    end
  end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
// Bench for the evacuation brake and fault block
module tb_top;
  localparam int unsigned PH = 20; // Short timed half period
  localparam int unsigned AD = 50; // Short acknowledge delay
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, retry = 1'h0;
  logic        rescue_active = 1'h0, install_stopped = 1'h0, encoder_ok = 1'h0;
  logic        v1_switch_off = 1'h0;
  logic        brake_open_fb = 1'h0, error_detect = 1'h0, monitor_din = 1'h0;
  logic        power_fail_set_select = 1'h0, hreadyout, hresp, pulsed_brake_function;
  logic        fault_output, drive_ready_output, brake_control_output, early_brake_close;
  logic        led_green, set2_active, monitor_active, monitor_double_arrow, monitor_dir_up;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  travel_req, travel_cmd = 4'h0;
  logic [9:0]  error_code = 10'h000;
  logic [15:0] monitor_speed;
  logic [23:0] monitor_distance;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  ebfc_pkg::ebfc_sample_s sample = '0;
  int          miscompares = 0, n_tests = 0, cycles = 0;

  ebfc_top #(.PULSE_HALF(PH), .ACK_DELAY(AD), .LED_PERIOD(40)) dut_u (
    .hclk, .hresetn, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .sample, .travel_req, .rescue_active,
    .install_stopped, .encoder_ok, .brake_open_fb, .error_detect, .error_code, .monitor_din,
    .power_fail_set_select, .v1_switch_off, .dist_valid(1'h0), .dist_remaining(16'h0),
    .pulsed_brake_function, .fault_output, .drive_ready_output, .brake_control_output,
    .early_brake_close, .led_green, .set2_active, .monitor_active, .monitor_double_arrow,
    .monitor_dir_up, .monitor_speed, .monitor_distance);
  ebfc_lift_model lift_u (.hclk, .hresetn, .travel_cmd, .retry, .fault_output,
    .travel_req_r(travel_req));

  // Bus clock, 50 ns period
  always #25 hclk = ~hclk;

  // Cut a hung run short
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // One single AHB-Lite word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'h0, a, 32'h0);
    check(what, rd, exp);
    check("resp", hresp, 1'h0);
  endtask

  // One control sample, then let the outputs settle
  task automatic smp(input logic [15:0] s, input logic u, input logic [7:0] d);
    @(posedge hclk);
    sample <= '{1'h1, s, u, d};
    @(posedge hclk);
    sample.valid <= 1'h0;
    repeat (2) @(negedge hclk);
  endtask

  task automatic do_reset;
    @(posedge hclk);
    hresetn <= 1'h0;
    cyc(3);
    hresetn <= 1'h1;
  endtask

  task automatic t_regs;
    rdchk("ctrl", 32'h0, 32'h0);
    rdchk("limit", 32'h4, 32'h3C);
    ahb(1'h1, 32'h8, 32'h23);
    rdchk("stop dist", 32'h8, 32'h23);
    ahb(1'h1, 32'h40, 32'h5A);
    rdchk("unmapped", 32'h40, 32'h0);
    ahb(1'h1, 32'h24, 32'h64);
    ahb(1'h1, 32'h0, 32'h14);
    rdchk("copy v2", 32'h34, 32'h32);
    rdchk("copy off", 32'h0, 32'h4);
    power_fail_set_select <= 1'h1;
    travel_cmd <= 4'h1;
    v1_switch_off <= 1'h1;
    cyc(3);
    check("set2", set2_active, 1'h1);
    check("early", early_brake_close, 1'h1);
    check("brake early", brake_control_output, 1'h0);
    power_fail_set_select <= 1'h0;
    $display("test regs done");
  endtask

  task automatic t_speed;
    ahb(1'h1, 32'h0, 32'h1);
    rescue_active <= 1'h1;
    encoder_ok <= 1'h1;
    smp(16'h32, 1'h1, 8'h0);
    check("pb below", pulsed_brake_function, 1'h1);
    smp(16'h3C, 1'h1, 8'h0);
    check("pb equal", pulsed_brake_function, 1'h1);
    smp(16'h3D, 1'h1, 8'h0);
    check("pb above", pulsed_brake_function, 1'h0);
    smp(16'h3C, 1'h1, 8'h0);
    check("pb hold", pulsed_brake_function, 1'h0);
    $display("test speed cycle done");
  endtask

  task automatic t_timed;
    int n;
    @(posedge hclk);
    rescue_active <= 1'h0;
    install_stopped <= 1'h1;
    ahb(1'h1, 32'h0, 32'h3);
    cyc(PH);
    check("pb blocked", pulsed_brake_function, 1'h0);
    for (int k = 0; k < 2; k++) begin
      install_stopped <= (k == 0);
      encoder_ok <= (k == 0);
      brake_open_fb <= 1'h1;
      n = 0;
      while (pulsed_brake_function !== 1'h1 && n < 100) begin
        @(negedge hclk);
        n++;
      end
      n = 0;
      while (pulsed_brake_function === 1'h1 && n < 100) begin
        @(negedge hclk);
        n++;
      end
      check("pb half period", n, PH);
      @(posedge hclk);
    end
    ahb(1'h1, 32'h0, 32'h0);
    $display("test timed cycle done");
  endtask

  task automatic t_fault;
    logic [9:0] codes [3] = '{10'h383, 10'h3E8, 10'h384};
    travel_cmd <= 4'h1;
    cyc(4);
    check("brake travel", brake_control_output, 1'h1);
    foreach (codes[i]) begin
      error_detect <= 1'h1;
      error_code <= codes[i];
      @(posedge hclk);
      error_detect <= 1'h0;
      @(negedge hclk);
      check("fault out", fault_output, 1'h0);
      check("ready out", drive_ready_output, 1'h0);
      check("brake out", brake_control_output, 1'h0);
      cyc(11);
      retry <= 1'h1;
      cyc(2);
      retry <= 1'h0;
      cyc(AD - 4);
      check("no early ack", fault_output, 1'h0);
      cyc(8);
      check("auto ack", fault_output, i != 2);
      cyc(4);
    end
    travel_cmd <= 4'h0;
    do_reset();
    $display("test fault done");
  endtask

  task automatic t_monitor;
    ahb(1'h1, 32'h0, 32'h2800);
    monitor_din <= 1'h1;
    cyc(4);
    check("wrong code", monitor_active, 1'h0);
    check("ready free", drive_ready_output, 1'h1);
    ahb(1'h1, 32'h0, 32'h2900);
    travel_cmd <= 4'h1;
    cyc(4);
    check("monitor on", monitor_active, 1'h1);
    check("ready lock", drive_ready_output, 1'h0);
    check("brake lock", brake_control_output, 1'h0);
    smp(16'h46, 1'h1, 8'h05);
    check("double", monitor_double_arrow, 1'h1);
    check("speed", monitor_speed, 16'h46);
    smp(16'h1E, 1'h0, 8'hFD);
    check("single", monitor_double_arrow, 1'h0);
    check("dir", monitor_dir_up, 1'h0);
    check("distance", monitor_distance, 24'h2);
    $display("test monitor done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_regs();
    t_speed();
    t_timed();
    t_fault();
    t_monitor();
    report_and_stop();
  end
endmodule
